// ===== ocr_recorder.sv
`timescale 1ns/1ps
`include "ocr_params.svh"
// Summary of operation
// R1: ON and OFF events per status change.
// R2: Filter passes ON, OFF or both.
// R3: Events carry change time stamp.
// R4: Clearable start, trip, blocked counters.
// R5: Status outputs exported for logic use.
// R6: Twelve time-stamped records per instance.
// R7: Records only on start/trip/block ON.
// R8: Record holds stamp, event, currents, time.
// R9: Record holds active setting group.
// R10: Blocking input sampled each processing cycle.
// R11: Full store overwrites oldest record.
module ocr_recorder
  import ocr_pkg::*;
#(
  parameter int NUM_INST = `OCR_INSTANCES,
  parameter int DEPTH    = `OCR_RECORD_DEPTH
) (
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Processing-cycle strobe and time base.
  input  wire logic                   cycle_en,
  input  wire logic [63:0]            time_stamp,
  // Stage status and measurements, one per instance.
  input  wire ocr_status_t            status_in   [NUM_INST],
  input  wire logic [NUM_INST-1:0]    block_in,
  input  wire ocr_meas_t              meas_in     [NUM_INST],
  // User selections.
  input  wire logic [1:0]             filter_sel,
  input  wire logic [NUM_INST-1:0]    cnt_clear,
  // Event output with handshake.
  output ocr_event_t                  evt_data,
  output logic                        evt_valid,
  input  wire logic                   evt_ready,
  // Status exported to outputs and user logic.
  output ocr_status_t                 status_out  [NUM_INST],
  // Cumulative counters.
  output logic [15:0]                 cnt_start   [NUM_INST],
  output logic [15:0]                 cnt_trip    [NUM_INST],
  output logic [15:0]                 cnt_block   [NUM_INST],
  // Record read port.
  input  wire logic [1:0]             rd_inst,
  input  wire logic [3:0]             rd_index,
  output ocr_record_t                 rd_record,
  output logic [3:0]                  rd_count
);

  // ==========================================================
  // Status sampling
  // ==========================================================
  localparam int NSRC = `OCR_NUM_SRC;
  localparam int NTOT = NUM_INST * NSRC;

  logic [NSRC-1:0] cur_reg  [NUM_INST];
  logic [NSRC-1:0] prev_reg [NUM_INST];
  logic [NTOT-1:0] pend_reg;
  logic [NTOT-1:0] pend_on_reg;
  logic [63:0]     pend_ts_reg [NTOT];
  logic            sampled_reg;

  // Flatten status of each instance into source order.
  function automatic logic [NSRC-1:0] flat(input ocr_status_t s, input logic blk);
    flat = {s.trip_ph[2], s.trip_ph[1], s.trip_ph[0],
            s.start_ph[2], s.start_ph[1], s.start_ph[0],
            blk, s.trip, s.start};
  endfunction

  // R10: sample per cycle
  // Status and blocking inputs are only taken on the processing strobe so the blocking view is stable for a cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_INST; i++) begin
        cur_reg[i]  <= '0;
        prev_reg[i] <= '0;
      end
      sampled_reg <= 1'b0;
    end else begin
      sampled_reg <= cycle_en;
      if (cycle_en) begin
        for (int i = 0; i < NUM_INST; i++) begin
          prev_reg[i] <= cur_reg[i];
          cur_reg[i]  <= flat(status_in[i], block_in[i] | status_in[i].blocked);
        end
      end
    end
  end

  // R5: export status
  always_comb begin
    for (int i = 0; i < NUM_INST; i++) begin
      status_out[i].start    = cur_reg[i][0];
      status_out[i].trip     = cur_reg[i][1];
      status_out[i].blocked  = cur_reg[i][2];
      status_out[i].start_ph = cur_reg[i][5:3];
      status_out[i].trip_ph  = cur_reg[i][8:6];
    end
  end

  // ==========================================================
  // Event detection and filtering
  // ==========================================================
  logic [NTOT-1:0] chg;
  logic [NTOT-1:0] lvl;
  logic [NTOT-1:0] take;
  logic [$clog2(NTOT)-1:0] sel_idx;
  logic            sel_any;

  always_comb begin
    for (int i = 0; i < NUM_INST; i++) begin
      for (int s = 0; s < NSRC; s++) begin
        chg[i*NSRC+s] = sampled_reg & (cur_reg[i][s] ^ prev_reg[i][s]);
        lvl[i*NSRC+s] = cur_reg[i][s];
      end
    end
  end

  // Lowest pending index wins; one event leaves per accepted handshake.
  always_comb begin
    sel_idx = '0;
    sel_any = 1'b0;
    for (int k = NTOT-1; k >= 0; k--) begin
      if (pend_reg[k]) begin
        sel_idx = k[$clog2(NTOT)-1:0];
        sel_any = 1'b1;
      end
    end
  end

  always_comb begin
    take = '0;
    if (sel_any && (!evt_valid || evt_ready)) begin
      take[sel_idx] = 1'b1;
    end
  end

  // R1: on/off events
  // R2: event filter
  // A new change beats the hand-off of an older one; a quick re-toggle overwrites it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg    <= '0;
      pend_on_reg <= '0;
      for (int k = 0; k < NTOT; k++) pend_ts_reg[k] <= '0;
    end else begin
      for (int k = 0; k < NTOT; k++) begin
        if (chg[k] && (filter_sel == `OCR_FILT_BOTH ||
                       (filter_sel == `OCR_FILT_ON && lvl[k]) ||
                       (filter_sel == `OCR_FILT_OFF && !lvl[k]))) begin
          pend_reg[k]    <= 1'b1;
          pend_on_reg[k] <= lvl[k];
          // R3: stamp at change
          pend_ts_reg[k] <= time_stamp;
        end else if (take[k]) begin
          pend_reg[k] <= 1'b0;
        end
      end
    end
  end

  // Event output register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_valid <= 1'b0;
      evt_data  <= '0;
    end else if (!evt_valid || evt_ready) begin
      evt_valid <= sel_any;
      if (sel_any) begin
        evt_data.inst  <= 2'(sel_idx / NSRC);
        evt_data.src   <= 4'(sel_idx % NSRC);
        evt_data.on    <= pend_on_reg[sel_idx];
        evt_data.stamp <= pend_ts_reg[sel_idx];
      end
    end
  end

  // ==========================================================
  // Counters
  // ==========================================================
  // R4: clearable counters
  // A clear in the same cycle as a new occurrence keeps the occurrence.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_INST; i++) begin
        cnt_start[i] <= `OCR_CNT_RESET;
        cnt_trip[i]  <= `OCR_CNT_RESET;
        cnt_block[i] <= `OCR_CNT_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_INST; i++) begin
        if (chg[i*NSRC+0] && lvl[i*NSRC+0])
          cnt_start[i] <= cnt_clear[i] ? 16'h0001 : cnt_start[i] + 16'h0001;
        else if (cnt_clear[i])
          cnt_start[i] <= `OCR_CNT_RESET;
        if (chg[i*NSRC+1] && lvl[i*NSRC+1])
          cnt_trip[i] <= cnt_clear[i] ? 16'h0001 : cnt_trip[i] + 16'h0001;
        else if (cnt_clear[i])
          cnt_trip[i] <= `OCR_CNT_RESET;
        if (chg[i*NSRC+2] && lvl[i*NSRC+2])
          cnt_block[i] <= cnt_clear[i] ? 16'h0001 : cnt_block[i] + 16'h0001;
        else if (cnt_clear[i])
          cnt_block[i] <= `OCR_CNT_RESET;
      end
    end
  end

  // ==========================================================
  // Fault record store
  // ==========================================================
  // R6: per-instance store
  ocr_record_t rec_mem [NUM_INST][DEPTH];
  logic [3:0]  wr_ptr_reg [NUM_INST];
  logic [3:0]  cnt_reg    [NUM_INST];

  // R7: ON events only
  // R11: circular overwrite
  // Only one record per instance per cycle; start has priority over trip, then block.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_INST; i++) begin
        wr_ptr_reg[i] <= '0;
        cnt_reg[i]    <= '0;
        for (int d = 0; d < DEPTH; d++) rec_mem[i][d] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_INST; i++) begin
        for (int s = 2; s >= 0; s--) begin
          if (chg[i*NSRC+s] && lvl[i*NSRC+s]) begin
            // R8: record fields
            rec_mem[i][wr_ptr_reg[i]].stamp <= time_stamp;
            rec_mem[i][wr_ptr_reg[i]].src   <= 4'(s);
            // R9: setting group
            rec_mem[i][wr_ptr_reg[i]].meas  <= meas_in[i];
          end
        end
        if (|(chg[i*NSRC +: 3] & lvl[i*NSRC +: 3])) begin
          wr_ptr_reg[i] <= (wr_ptr_reg[i] == 4'(DEPTH-1)) ? 4'h0 : wr_ptr_reg[i] + 4'h1;
          if (cnt_reg[i] != 4'(DEPTH)) cnt_reg[i] <= cnt_reg[i] + 4'h1;
        end
      end
    end
  end

  // Read port: index 0 is the newest record of the selected instance.
  logic [4:0] rd_pos;
  always_comb begin
    rd_pos = 5'(wr_ptr_reg[rd_inst]) + 5'(DEPTH) - 5'h01 - 5'(rd_index);
    if (rd_pos >= 5'(DEPTH)) rd_pos = rd_pos - 5'(DEPTH);
    if (rd_pos >= 5'(DEPTH)) rd_pos = rd_pos - 5'(DEPTH);
  end

  // Registered read data.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_record <= '0;
      rd_count  <= '0;
    end else begin
      rd_record <= (4'(rd_index) < cnt_reg[rd_inst]) ? rec_mem[rd_inst][rd_pos[3:0]] : '0;
      rd_count  <= cnt_reg[rd_inst];
    end
  end

endmodule

// ===== ocr_params.svh
`ifndef OCR_PARAMS_SVH
`define OCR_PARAMS_SVH

// Number of fault records kept per stage instance.
`define OCR_RECORD_DEPTH    12
// Number of stage instances.
`define OCR_INSTANCES       4
// Event source codes, one per monitored status bit.
`define OCR_SRC_START       4'h0
`define OCR_SRC_TRIP        4'h1
`define OCR_SRC_BLOCK       4'h2
`define OCR_SRC_START_A     4'h3
`define OCR_SRC_START_B     4'h4
`define OCR_SRC_START_C     4'h5
`define OCR_SRC_TRIP_A      4'h6
`define OCR_SRC_TRIP_B      4'h7
`define OCR_SRC_TRIP_C      4'h8
`define OCR_NUM_SRC         9
// Filter selection codes.
`define OCR_FILT_BOTH       2'h0
`define OCR_FILT_ON         2'h1
`define OCR_FILT_OFF        2'h2
// Longest remaining trip time in milliseconds.
`define OCR_TRIP_REM_MAX_MS 32'd1800000
// Counter reset value.
`define OCR_CNT_RESET       16'h0000

`endif

// ===== ocr_pkg.sv
package ocr_pkg;

  // Stage status as delivered by one overcurrent stage.
  typedef struct packed {
    logic       start;
    logic       trip;
    logic       blocked;
    logic [2:0] start_ph;
    logic [2:0] trip_ph;
  } ocr_status_t;

  // Analog snapshot supplied with the status.
  typedef struct packed {
    logic [15:0] pre_trig_cur;
    logic [15:0] fault_cur;
    logic [15:0] pre_fault_cur;
    logic [31:0] trip_rem_ms;
    logic [2:0]  set_group;
    logic [3:0]  fault_type;
  } ocr_meas_t;

  // One time-stamped event towards the main event buffer.
  typedef struct packed {
    logic [1:0]  inst;
    logic [3:0]  src;
    logic        on;
    logic [63:0] stamp;
  } ocr_event_t;

  // One stored fault record.
  typedef struct packed {
    logic [63:0] stamp;
    logic [3:0]  src;
    ocr_meas_t   meas;
  } ocr_record_t;

endpackage

// ===== ocr_sink_model.sv
`timescale 1ns/1ps
// ====================
// Event buffer model
module ocr_sink_model
  import ocr_pkg::*;
(
  // Clock, reset and pacing.
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  // Event handshake.
  input  wire ocr_event_t evt_data,
  input  wire logic       evt_valid,
  output logic            evt_ready,
  // Observation.
  output ocr_event_t      last_evt,
  output int              n_evt
);
  // Slow mode drops ready every other cycle, so the source must hold its offer.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) evt_ready <= 1'b0;
    else evt_ready <= slow ? ~evt_ready : 1'b1;
  end
  // An event is taken at the edge where valid and ready are both high.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_evt <= '0;
      n_evt    <= 0;
    end else if (evt_valid && evt_ready) begin
      last_evt <= evt_data;
      n_evt    <= n_evt + 1;
    end
  end
endmodule

// ===== ocr_recorder_sva.sv
`timescale 1ns/1ps
`include "ocr_params.svh"
// ====================
// Recorder port checks
module ocr_recorder_sva
  import ocr_pkg::*;
#(
  parameter int NUM_INST = 4,
  parameter int DEPTH    = 12
) (
  // Observed ports.
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic                cycle_en,
  input wire logic [1:0]          filter_sel,
  input wire logic [NUM_INST-1:0] cnt_clear,
  input wire ocr_event_t          evt_data,
  input wire logic                evt_valid,
  input wire logic                evt_ready,
  input wire ocr_status_t         status_out [NUM_INST],
  input wire logic [15:0]         cnt_start  [NUM_INST],
  input wire logic [3:0]          rd_count
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_offer_holds: assert property (evt_valid && !evt_ready
    |=> evt_valid && $stable(evt_data))
    else $error("offer dropped or changed");
  chk_filter_on: assert property (evt_valid && filter_sel == `OCR_FILT_ON |-> evt_data.on)
    else $error("off event passed on-only filter");
  chk_filter_off: assert property (evt_valid && filter_sel == `OCR_FILT_OFF |-> !evt_data.on)
    else $error("on event passed off-only filter");
  chk_filter_none: assert property (filter_sel == 2'h3 |-> !evt_valid)
    else $error("event passed closed filter");
  chk_store_depth: assert property (rd_count <= DEPTH)
    else $error("record count above depth");
  chk_clear_counter: assert property (cnt_clear[2] |=> cnt_start[2] <= 16'h0001)
    else $error("counter not cleared");
  chk_count_step: assert property ($changed(cnt_start[2]) && !$past(cnt_clear[2])
    |-> cnt_start[2] == $past(cnt_start[2]) + 16'h0001)
    else $error("counter stepped wrongly");
  chk_status_sampled: assert property ($changed(status_out[1]) |-> $past(cycle_en))
    else $error("status changed outside sample");
endmodule
bind ocr_recorder ocr_recorder_sva #(.NUM_INST(NUM_INST), .DEPTH(DEPTH)) u_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .cycle_en(cycle_en), .filter_sel(filter_sel),
  .cnt_clear(cnt_clear), .evt_data(evt_data), .evt_valid(evt_valid),
  .evt_ready(evt_ready), .status_out(status_out), .cnt_start(cnt_start), .rd_count(rd_count));

// ===== ocr_recorder_tb_top.sv
`timescale 1ns/1ps
// ====================
// Recorder testbench
module ocr_recorder_tb_top;
  import ocr_pkg::*;
  logic ref_clk = 0, rst_n = 0, cycle_en = 0, slow = 0, evt_valid, evt_ready;
  logic [63:0] time_stamp = '0;
  logic [3:0]  block_in = '0, cnt_clear = '0, rd_index = '0, rd_count;
  logic [1:0]  filter_sel = '0, rd_inst = '0;
  ocr_status_t status_in [4], status_out [4];
  ocr_meas_t   meas_in [4];
  ocr_event_t  evt_data, last_evt;
  ocr_record_t rd_record;
  logic [15:0] cnt_start [4], cnt_trip [4], cnt_block [4];
  int n_evt, error_cnt = 0, checks = 0;
  int bitpos [9] = '{8, 7, 6, 3, 4, 5, 0, 1, 2};
  ocr_recorder u_ocr_recorder (.ref_clk(ref_clk), .rst_n(rst_n), .cycle_en(cycle_en),
    .time_stamp(time_stamp), .status_in(status_in), .block_in(block_in), .meas_in(meas_in),
    .filter_sel(filter_sel), .cnt_clear(cnt_clear), .evt_data(evt_data),
    .evt_valid(evt_valid), .evt_ready(evt_ready), .status_out(status_out),
    .cnt_start(cnt_start), .cnt_trip(cnt_trip), .cnt_block(cnt_block), .rd_inst(rd_inst),
    .rd_index(rd_index), .rd_record(rd_record), .rd_count(rd_count));
  ocr_sink_model u_ocr_sink_model (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .evt_data(evt_data), .evt_valid(evt_valid), .evt_ready(evt_ready),
    .last_evt(last_evt), .n_evt(n_evt));
  // Free-running clock.
  always #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One sample strobe with the given status, then time for the pipeline to settle.
  task automatic pulse(input int k, input ocr_status_t s, input logic b);
    status_in[k] = s;
    block_in[k] = b;
    cycle_en = 1'b1;
    @(negedge ref_clk) cycle_en = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic wait_evt(input int n0);
    for (int t = 0; t < 50 && n_evt == n0; t++) @(negedge ref_clk);
  endtask
  // Every source raises a stamped ON then OFF event through a stalling buffer.
  task automatic t_events;
    int n0;
    slow = 1'b1;
    for (int s = 0; s < 9; s++) begin
      time_stamp = 64'h100 + 64'(s);
      n0 = n_evt;
      pulse(1, ocr_status_t'(9'h1 << bitpos[s]), 1'b0);
      wait_evt(n0);
      chk(80'(last_evt), 80'({2'd1, 4'(s), 1'b1, time_stamp}));
      chk(80'(status_out[1]), 80'(9'h1 << bitpos[s]));
      n0 = n_evt;
      time_stamp = 64'h200 + 64'(s);
      pulse(1, '0, 1'b0);
      wait_evt(n0);
      chk(80'(last_evt), 80'({2'd1, 4'(s), 1'b0, time_stamp}));
    end
    slow = 1'b0;
  endtask
  // Each filter code passes the expected number of events.
  task automatic t_filter;
    int n0;
    int exp_n [4] = '{2, 1, 1, 0};
    for (int f = 0; f < 4; f++) begin
      filter_sel = 2'(f);
      n0 = n_evt;
      pulse(0, 9'h100, 1'b0);
      pulse(0, '0, 1'b0);
      repeat (12) @(negedge ref_clk);
      chk(80'(n_evt - n0), 80'(exp_n[f]));
      if (f == 1 || f == 2) chk(80'(last_evt.on), 80'(f == 1));
    end
  endtask
  // Counters count each occurrence and clear on request.
  task automatic t_counters;
    filter_sel = 2'h3;
    repeat (3) begin
      pulse(2, 9'h100, 1'b0);
      pulse(2, '0, 1'b0);
    end
    pulse(2, 9'h080, 1'b0);
    pulse(2, '0, 1'b0);
    pulse(2, '0, 1'b1);
    pulse(2, '0, 1'b0);
    chk(80'({cnt_start[2], cnt_trip[2], cnt_block[2]}), 80'(48'h0003_0001_0001));
    cnt_clear[2] = 1'b1;
    @(negedge ref_clk) cnt_clear[2] = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(80'({cnt_start[2], cnt_trip[2], cnt_block[2]}), 80'(0));
  endtask
  task automatic rd(input logic [3:0] idx);
    rd_index = idx;
    repeat (2) @(negedge ref_clk);
  endtask
  // Fourteen faults overflow the store; the oldest two are lost.
  task automatic t_records;
    rd_inst = 2'd3;
    for (int i = 0; i < 14; i++) begin
      meas_in[3].fault_cur = 16'(i);
      meas_in[3].set_group = 3'(i);
      time_stamp = 64'h1000 + 64'(i);
      pulse(3, 9'h100, 1'b0);
      pulse(3, '0, 1'b0);
      if (i == 0) chk(80'(rd_count), 80'(1));
    end
    rd(4'd0);
    chk(80'(rd_count), 80'(12));
    chk(80'({rd_record.src, rd_record.meas.fault_cur}), 80'({4'h0, 16'd13}));
    chk(80'(rd_record.meas.set_group), 80'(3'd5));
    chk(80'(rd_record.stamp), 80'(64'h100d));
    rd(4'd11);
    chk(80'(rd_record.meas.fault_cur), 80'(16'd2));
    rd(4'd12);
    chk(80'(|rd_record), 80'(0));
    rd_inst = 2'd2;
    rd(4'd0);
    chk(80'(rd_count), 80'(5));
  endtask
  // Main sequence.
  initial begin
    foreach (status_in[i]) begin
      status_in[i] = '0;
      meas_in[i] = '0;
    end
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_events();
    t_filter();
    t_counters();
    t_records();
    end_sim();
  end
  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end
endmodule
